// [rtl/edge_irq_defs.vh]
// Constants for the edge interrupt shaper and DMA base pointer block.
`ifndef EDGE_IRQ_DEFS_VH
`define EDGE_IRQ_DEFS_VH
// Register byte offsets.
`define OFS_EDGE_IRQ_TIMING 12'h340
`define OFS_DMA_BASE_POINTER 12'h344
`define OFS_IRQ_STATUS 12'h348
`define OFS_IRQ_MASK 12'h34C
`define OFS_SHAPER_CTRL 12'h350
// Field positions inside the timing register.
`define GAP_MSB 31
`define GAP_LSB 24
`define HOLD_MSB 15
`define HOLD_LSB 0
// Reset values.
`define HOLD_RESET 16'h000F
`define GAP_RESET 8'h00
`define DMA_BASE_RESET 16'h0000
// Microframe timing: 125 us at 25 MHz.
`define UFRAME_NS 125000
`define CLK_NS 40
`define UFRAME_CYCLES 16'h0C35
// Status bit positions.
`define ST_PULSE 0
`define ST_DROP 1
// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [rtl/uframe_tick_gen.v]
// Microframe tick divider producing a one-cycle enable every 125 us.
`timescale 1ns/1ps
`default_nettype none
`include "edge_irq_defs.vh"
module uframe_tick_gen #(
	parameter [15:0] TICK_CYCLES = `UFRAME_CYCLES
) (
	input wire clk_sys,
	input wire reset_n,
	output reg tick
);
	reg [15:0] cnt_q; // Cycles elapsed within the current microframe.

	// Count up through the microframe and pulse the tick on wrap.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			cnt_q <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt_q == TICK_CYCLES - 16'h0001) begin
			cnt_q <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule // uframe_tick_gen
`default_nettype wire

// [rtl/edge_irq_shaper.v]
// Edge interrupt pulse shaper with spacing control and DMA base pointer.
// Notes on behaviour
// - Enforce gap microframes between edge pulses.
// - Level mode ignores the spacing gap.
// - Zero gap fires edge pulse immediately.
// - Edge pulse held for hold-count plus one cycles, two cycles at hold count zero.
// - Hold count resets to 000Fh.
// - Timing register at 0340h, gap/hold fields.
// - DMA base address drives DMA start.
// - DMA base at 0344h, write-only, zero reset.
`timescale 1ns/1ps
`default_nettype none
`include "edge_irq_defs.vh"
module edge_irq_shaper #(
	parameter [15:0] TICK_CYCLES = `UFRAME_CYCLES
) (
	input wire clk_sys,
	input wire reset_n,
	// AXI4-Lite write address channel.
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data channel.
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response channel.
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address channel.
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data channel.
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Interrupt event from the controller core, same clock domain.
	input wire irq_event,
	// Processor interrupt line and the DMA start address.
	output reg irq_line,
	output reg [15:0] dma_start_addr,
	// Summary interrupt of the shaper's own status bits.
	output wire shaper_irq
);
	// Timing register fields.
	reg [7:0] gap_q; // Spacing in microframes.
	reg [15:0] pulse_hold_cycles_q; // Edge pulse hold count.
	// Control register: bit 0 selects level mode, bit 1 inverts polarity.
	reg level_mode_q;
	reg active_high_q;
	// Sticky status and mask.
	reg [1:0] status_q;
	reg [1:0] mask_q;
	// Write channel holding registers.
	reg aw_held_q;
	reg w_held_q;
	reg [11:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	// Shaper state.
	reg [16:0] hold_cnt_q; // Cycles remaining of the current pulse.
	reg [7:0] gap_cnt_q; // Microframe ticks since the last pulse began, counted only while spacing blocks.
	reg gap_busy_q; // High while spacing still blocks a new pulse.
	reg pending_q; // An event waits for the spacing to expire or the live pulse to end.
	reg pulsing_q; // Edge pulse is currently asserted.
	wire tick; // Microframe enable.
	wire wr_fire;
	wire [31:0] wmask;
	wire start_pulse;
	wire ev_any;
	wire set_pulse_st;
	wire set_drop_st;
	wire irq_active;
	integer i;

	// Microframe divider providing the spacing time base.
	uframe_tick_gen #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.tick(tick)
	);

	// Accept each write channel independently, one write at a time.
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	assign wr_fire = aw_held_q && w_held_q;
	assign s_axi_arready = !s_axi_rvalid;

	// Expand byte strobes into a bit mask.
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb = gb + 1) begin : g_strb
			assign wmask[gb*8 +: 8] = {8{w_strb_q[gb]}};
		end
	endgenerate

	// Capture address and data as they arrive, in either order.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_q <= 1'b0;
			end
		end
	end

	// Write response follows once both halves have been used.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			case (aw_addr_q)
				`OFS_EDGE_IRQ_TIMING, `OFS_DMA_BASE_POINTER, `OFS_IRQ_STATUS,
				`OFS_IRQ_MASK, `OFS_SHAPER_CTRL: begin
					s_axi_bresp <= `RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= `RESP_SLVERR;
				end
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register writes; reserved bits are dropped, software keeps them zero.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			gap_q <= `GAP_RESET;
			pulse_hold_cycles_q <= `HOLD_RESET;
			dma_start_addr <= `DMA_BASE_RESET;
			mask_q <= 2'h0;
			level_mode_q <= 1'b0;
			active_high_q <= 1'b0;
		end else if (wr_fire) begin
			case (aw_addr_q)
				`OFS_EDGE_IRQ_TIMING: begin
					// Gap in bits 31..24, hold count in bits 15..0.
					gap_q <= (gap_q & ~wmask[`GAP_MSB:`GAP_LSB])
						| (w_data_q[`GAP_MSB:`GAP_LSB] & wmask[`GAP_MSB:`GAP_LSB]);
					pulse_hold_cycles_q <= (pulse_hold_cycles_q & ~wmask[15:0])
						| (w_data_q[`HOLD_MSB:`HOLD_LSB] & wmask[15:0]);
				end
				`OFS_DMA_BASE_POINTER: begin
					// Write-only start address used for DMA reads and writes.
					dma_start_addr <= (dma_start_addr & ~wmask[15:0])
						| (w_data_q[15:0] & wmask[15:0]);
				end
				`OFS_IRQ_MASK: begin
					if (w_strb_q[0]) begin
						mask_q <= w_data_q[1:0];
					end
				end
				`OFS_SHAPER_CTRL: begin
					if (w_strb_q[0]) begin
						level_mode_q <= w_data_q[0];
						active_high_q <= w_data_q[1];
					end
				end
				default: begin
					// Unmapped, or status (cleared in its own block): nothing stored.
				end
			endcase
		end
	end

	// Read channel: one beat, answered the cycle after the address is taken.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			case (s_axi_araddr)
				`OFS_EDGE_IRQ_TIMING: begin
					s_axi_rdata <= {gap_q, 8'h00, pulse_hold_cycles_q};
				end
				`OFS_DMA_BASE_POINTER: begin
					s_axi_rdata <= 32'h00000000; // Write-only, reads zero.
				end
				`OFS_IRQ_STATUS: begin
					s_axi_rdata <= {30'h00000000, status_q};
				end
				`OFS_IRQ_MASK: begin
					s_axi_rdata <= {30'h00000000, mask_q};
				end
				`OFS_SHAPER_CTRL: begin
					s_axi_rdata <= {23'h000000, gap_busy_q, pulsing_q, pending_q,
						4'h0, active_high_q, level_mode_q};
				end
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// In edge mode a pulse starts when an event or a waiting event meets an open gap and no pulse is live.
	assign ev_any = irq_event || pending_q;
	assign start_pulse = !level_mode_q && ev_any && !pulsing_q
		&& (!gap_busy_q || gap_q == 8'h00);

	// Edge pulse timing and spacing counter.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			hold_cnt_q <= 17'h00000;
			pulsing_q <= 1'b0;
			pending_q <= 1'b0;
			gap_cnt_q <= 8'h00;
			gap_busy_q <= 1'b0;
		end else begin
			if (level_mode_q) begin
				// Level mode: no pulse shaping and no spacing.
				pending_q <= 1'b0;
				pulsing_q <= 1'b0;
				gap_busy_q <= 1'b0;
			end else if (start_pulse) begin
				// Hold count N of 1 or more asserts the pulse N+1 cycles; N of 0 asserts it 2 cycles.
				hold_cnt_q <= {1'b0, pulse_hold_cycles_q};
				pulsing_q <= 1'b1;
				pending_q <= 1'b0;
				gap_cnt_q <= 8'h00; // Spacing measured from pulse start.
				gap_busy_q <= (gap_q != 8'h00);
			end else begin
				if (irq_event) begin
					pending_q <= 1'b1; // Held back by spacing or a live pulse.
				end
				if (pulsing_q) begin
					// The start cycle already drove the line, so stop one count early.
					if (hold_cnt_q <= 17'h00001) begin
						pulsing_q <= 1'b0;
					end else begin
						hold_cnt_q <= hold_cnt_q - 17'h00001;
					end
				end
				if (gap_busy_q && tick) begin
					// Advance one per microframe; release at the programmed gap.
					if (gap_cnt_q + 8'h01 >= gap_q) begin
						gap_busy_q <= 1'b0;
					end
					gap_cnt_q <= gap_cnt_q + 8'h01;
				end
			end
		end
	end

	// Processor interrupt line, registered, polarity selectable.
	assign irq_active = level_mode_q ? irq_event : (pulsing_q || start_pulse);
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			irq_line <= 1'b1;
		end else begin
			irq_line <= active_high_q ? irq_active : !irq_active;
		end
	end

	// Sticky status: pulse issued, and event held back by spacing or a live pulse.
	assign set_pulse_st = start_pulse;
	assign set_drop_st = irq_event && !start_pulse && !level_mode_q;
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			status_q <= 2'h0;
		end else begin
			for (i = 0; i < 2; i = i + 1) begin
				if (wr_fire && aw_addr_q == `OFS_IRQ_STATUS && w_strb_q[0]
					&& w_data_q[i]) begin
					status_q[i] <= 1'b0;
				end
				// Set wins over a simultaneous clear.
				if ((i == `ST_PULSE && set_pulse_st) || (i == `ST_DROP && set_drop_st)) begin
					status_q[i] <= 1'b1;
				end
			end
		end
	end

	assign shaper_irq = |(status_q & mask_q);
endmodule // edge_irq_shaper
`default_nettype wire

// [tb/edge_irq_chk.sv]
// Port checker for the edge interrupt shaper.
`timescale 1ns/1ps
`default_nettype none
module edge_irq_chk (
	input wire clk_sys,
	input wire reset_n,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire irq_line,
	input wire [15:0] dma_start_addr
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// A write is answered exactly two edges after it is taken.
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##2 s_axi_bvalid)
		else $error("write response not on time");
	// No new write half is taken while a response waits.
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	// The response is given once.
	write_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	// Read data follow one edge after the address.
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not on time");
	// No read address is taken while data wait.
	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read overlapped");
	// Read data are given once.
	read_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
	// Line idle and DMA start cleared right after reset.
	reset_state_a: assert property ($rose(reset_n) |-> irq_line && dma_start_addr == 16'h0000)
		else $error("bad state after reset");
	// A pulse lasts two cycles at least, even at hold count zero.
	pulse_min_a: assert property ($fell(irq_line) |=> !irq_line)
		else $error("interrupt pulse too short");
	// The DMA start only moves with a register write.
	dma_update_a: assert property ($changed(dma_start_addr) |-> ##[0:2] s_axi_bvalid)
		else $error("DMA start moved without a write");
endmodule // edge_irq_chk
`default_nettype wire

// [tb/irq_host_model.sv]
// Host interrupt input that times each low pulse of the interrupt line.
`timescale 1ns/1ps
`default_nettype none
module irq_host_model (
	input wire logic clk_sys,
	input wire logic irq_line,
	output int width,
	output int fall,
	output int npulse
);
	int cyc = 0; // Free cycle count.
	int run = 0; // Length of the pulse in progress.
	// Sample the active-low line each edge and log start and width of pulses.
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (!irq_line) begin
			run <= run + 1;
			if (run == 0) begin
				fall <= cyc;
				npulse <= npulse + 1;
			end
		end else if (run != 0) begin
			width <= run;
			run <= 0;
		end
	end
endmodule // irq_host_model
`default_nettype wire

// [tb/tb_edge_irq_pulse_shaper_dma_base.sv]
// Self-checking bench for the edge interrupt shaper.
`timescale 1ns/1ps
`default_nettype none
`include "edge_irq_defs.vh"
module tb_edge_irq_pulse_shaper_dma_base;
	logic clk_sys = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, irq_event = 0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000, rd, rdata;
	logic [1:0] bresp, rresp, resp;
	logic awready, wready, bvalid, arready, rvalid, irq_line, shaper_irq;
	logic [15:0] dma_start_addr;
	int num_errors = 0, compares = 0, cycles = 0, seed = 72;
	int width, fall, npulse, h, f1, n0;
	integer exp_timing = 32'h0000000F, exp_dma; // Reference register contents.
	edge_irq_shaper #(.TICK_CYCLES(16'h000A)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.irq_event(irq_event), .irq_line(irq_line), .dma_start_addr(dma_start_addr),
		.shaper_irq(shaper_irq));
	irq_host_model u_host (.clk_sys(clk_sys), .irq_line(irq_line), .width(width), .fall(fall),
		.npulse(npulse));
	always #20 clk_sys = ~clk_sys;
	// Cut a hang short after a generous cycle budget.
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			conclude();
		end
	end
	task automatic conclude();
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One bus write; each half drops when taken, bready stays up until the answer.
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask
	// One bus read.
	task automatic rdr(input logic [11:0] a);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	// Raise the event input for n cycles.
	task automatic ev(input int n);
		@(posedge clk_sys) irq_event <= 1'b1;
		repeat (n) @(posedge clk_sys);
		irq_event <= 1'b0;
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		rdr(`OFS_EDGE_IRQ_TIMING);
		chk(rd, exp_timing);
		exp_dma = $random(seed) & 32'h0000FFFF;
		wr(`OFS_DMA_BASE_POINTER, exp_dma);
		chk(32'(dma_start_addr), exp_dma);
		rdr(`OFS_DMA_BASE_POINTER);
		chk(rd, 32'h00000000);
		rdr(12'h360);
		chk(32'(resp), 32'(`RESP_SLVERR));
		wr(12'h360, 32'h00000000);
		chk(32'(resp), 32'(`RESP_SLVERR));
		// Random hold count, no spacing: two pulses back to back.
		h = 1 + {$random(seed)} % 8;
		exp_timing = h;
		wr(`OFS_EDGE_IRQ_TIMING, exp_timing);
		rdr(`OFS_EDGE_IRQ_TIMING);
		chk(rd, exp_timing);
		repeat (2) begin
			ev(1);
			@(posedge clk_sys);
			chk(32'(irq_line), 32'h00000000);
			repeat (h + 2) @(posedge clk_sys);
			chk(width, h + 1);
		end
		// Gap of two ticks: the second event waits and is flagged.
		exp_timing = 32'h02000001;
		wr(`OFS_EDGE_IRQ_TIMING, exp_timing);
		ev(1);
		repeat (4) @(posedge clk_sys);
		f1 = fall;
		ev(1);
		repeat (30) @(posedge clk_sys);
		chk(32'(fall - f1 > 10 && fall - f1 <= 22), 32'h00000001);
		rdr(`OFS_IRQ_STATUS);
		chk(rd & 32'h00000003, 32'h00000003);
		chk(32'(shaper_irq), 32'h00000000);
		wr(`OFS_IRQ_MASK, 32'h00000002);
		chk(32'(shaper_irq), 32'h00000001);
		wr(`OFS_IRQ_STATUS, 32'h00000003);
		chk(32'(shaper_irq), 32'h00000000);
		// Level mode with the gap still set: both events show at once.
		wr(`OFS_SHAPER_CTRL, 32'h00000001);
		n0 = npulse;
		ev(2);
		ev(2);
		repeat (4) @(posedge clk_sys);
		chk(npulse - n0, 2);
		// Active-high polarity in level mode: the line rises with the event.
		wr(`OFS_SHAPER_CTRL, 32'h00000003);
		ev(2);
		chk(32'(irq_line), 32'h00000001);
		conclude();
	end
endmodule // tb_edge_irq_pulse_shaper_dma_base
bind edge_irq_shaper edge_irq_chk u_chk (.clk_sys, .reset_n, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .irq_line, .dma_start_addr);
`default_nettype wire
